// *** shared/lec_pkg.sv ***
// lec_pkg: register map, field layout, start levels and carriers
// assumes the enhancement register sits at its config-space offset
package lec_pkg;

	// register map
	localparam logic [7:0] LEC_SETTINGS_OFFSET = 8'hf4;
	localparam logic [31:0] LEC_SETTINGS_RESET = 32'h0000_1000;
	localparam logic [31:0] LEC_WRITABLE_MASK = 32'h0000_3086;

	// field positions
	localparam int LEC_LEVEL_LSB = 12;
	localparam int LEC_PRIO_BIT = 7;
	localparam int LEC_PHYPROG_BIT = 6;
	localparam int LEC_IDLE_BIT = 2;
	localparam int LEC_ACCEL_BIT = 1;
	localparam int LEC_BYTE_BITS = 8;
	localparam int LEC_BYTES_PER_WORD = 4;

	// start level codes
	localparam logic [1:0] LEC_LVL_2K = 2'h0;
	localparam logic [1:0] LEC_LVL_1K7 = 2'h1;
	localparam logic [1:0] LEC_LVL_1K = 2'h2;
	localparam logic [1:0] LEC_LVL_512 = 2'h3;

	// start levels in bytes
	localparam logic [15:0] LEC_BYTES_2K = 16'h0800;
	localparam logic [15:0] LEC_BYTES_1K7 = 16'h06c0;
	localparam logic [15:0] LEC_BYTES_1K = 16'h0400;
	localparam logic [15:0] LEC_BYTES_512 = 16'h0200;

	// phy control line codes
	localparam logic [1:0] LEC_CTL_GRANT = 2'h3;
	localparam logic [1:0] LEC_CTL_IDLE = 2'h0;

	// one transmit fifo word with its end-of-packet token
	typedef struct packed {
		logic eop;
		logic [31:0] data;
	} lec_word_s;

	// settings as applied to the link
	typedef struct packed {
		logic [1:0] level;
		logic prio;
		logic idle;
		logic accel;
	} lec_settings_s;

endpackage

// *** core/lec_fifo.sv ***
// lec_fifo: flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module lec_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH + 1)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [CW-1:0] count_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_next;
	logic push;
	logic pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_reg[rd_ptr_reg];

	// occupancy after this cycle
	always_comb begin
		count_next = count_o;
		if (push && !pop) begin
			count_next = CW'(count_o + 1'b1);
		end else if (pop && !push) begin
			count_next = CW'(count_o - 1'b1);
		end
	end

	// storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// pointers, count and registered flags
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_o <= '0;
			in_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_reg + 1'b1);
			end
			count_o <= count_next;
			in_ready_o <= count_next != CW'(DEPTH);
			out_valid_o <= count_next != '0;
		end
	end

endmodule

// *** core/lec_turnaround.sv ***
// lec_turnaround: takes the phy control lines after a grant
// assumes the phy grants by driving the grant code on the lines
`timescale 1ns/10ps
module lec_turnaround (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// link side
	input wire logic link_req_i,
	input wire logic link_release_i,
	input wire logic idle_en_i,
	input wire logic [1:0] ctl_value_i,
	// phy control lines
	input wire logic [1:0] ctl_lines_i,
	output logic [1:0] ctl_lines_o,
	output logic ctl_lines_oe_o
);
	typedef enum logic [1:0] {LEC_TA_IDLE, LEC_TA_WAIT, LEC_TA_TURN, LEC_TA_DRIVE} lec_ta_e;

	lec_ta_e state_reg;
	lec_ta_e state_next;

	// grant and turnaround sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LEC_TA_IDLE: begin
				if (link_req_i) begin
					state_next = LEC_TA_WAIT;
				end
			end
			LEC_TA_WAIT: begin
				if (ctl_lines_i == lec_pkg::LEC_CTL_GRANT) begin
					state_next = idle_en_i ? LEC_TA_TURN : LEC_TA_DRIVE;
				end
			end
			LEC_TA_TURN: begin
				state_next = LEC_TA_DRIVE;
			end
			LEC_TA_DRIVE: begin
				if (link_release_i) begin
					state_next = LEC_TA_IDLE;
				end
			end
			default: begin
				state_next = LEC_TA_IDLE;
			end
		endcase
	end

	// state and line drivers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= LEC_TA_IDLE;
			ctl_lines_oe_o <= 1'b0;
			ctl_lines_o <= lec_pkg::LEC_CTL_IDLE;
		end else begin
			state_reg <= state_next;
			ctl_lines_oe_o <= state_next == LEC_TA_DRIVE;
			ctl_lines_o <= (state_next == LEC_TA_DRIVE) ? ctl_value_i : lec_pkg::LEC_CTL_IDLE;
		end
	end

	// grant seen in the waiting state
	sequence s_grant(logic idle);
		state_reg == LEC_TA_WAIT && ctl_lines_i == lec_pkg::LEC_CTL_GRANT && idle_en_i == idle;
	endsequence

	chk_turn_no_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_grant(1'b0) |=> ctl_lines_oe_o)
		else $error("lines not driven right after grant");
	chk_turn_one_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_grant(1'b1) |=> !ctl_lines_oe_o ##1 ctl_lines_oe_o)
		else $error("idle cycle after grant not kept");

endmodule

// *** core/lec_core.sv ***
// lec_core: link enhancement settings register and transmit start control
// assumes a config-space access port, an eeprom loader strobe and an
// external gate bit from the host controller control register
//
// Summary of operation
// - settings load from software or eeprom
// - settings act only while gate bit set
// - bits 31-14 read zero, read-only
// - level field 13-12 decodes four start levels
// - programmed level holds until an underrun
// - retry after underrun waits for whole packet
// - start at level or at packet end
// - fifo empties mid-packet means underrun, packet errored
// - 2K level sends only complete packets
// - bits 11-8 read zero, read-only
// - bit 7 enables priority arbitration requests
// - bits 5-3 read zero, read-only
// - bit 0 reads zero, read-only
// - without idle bit, drive right after grant
// - with idle bit, one idle cycle first
// - bit 1 advertises acceleration support to phy
// - bit 6 stays unassigned and read-only
`timescale 1ns/10ps
module lec_core #(
	parameter int DEPTH = 16,
	parameter int LVL_SHIFT = 0,
	parameter int CW = $clog2(DEPTH + 1)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// config-space access
	input wire logic cfg_sel_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	// serial eeprom loader
	input wire logic rom_load_i,
	input wire logic [31:0] rom_data_i,
	// host controller gate
	input wire logic host_enhancement_gate_i,
	// asynchronous transmit fill side
	input wire logic at_in_valid_i,
	output logic at_in_ready_o,
	input wire lec_pkg::lec_word_s at_in_data_i,
	// asynchronous transmit drain side
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output lec_pkg::lec_word_s tx_data_o,
	output logic tx_active_o,
	output logic tx_underrun_o,
	// phy interface
	input wire logic link_req_i,
	input wire logic link_release_i,
	input wire logic [1:0] link_ctl_value_i,
	input wire logic [1:0] phy_link_control_lines_i,
	output logic [1:0] phy_link_control_lines_o,
	output logic phy_link_control_lines_oe_o,
	output logic prio_req_en_o,
	output logic accel_adv_o
);
	typedef enum logic [1:0] {LEC_TX_IDLE, LEC_TX_SEND, LEC_TX_FLUSH} lec_tx_e;

	logic [31:0] settings_reg;
	logic [31:0] settings_next;
	logic [31:0] be_mask;
	lec_pkg::lec_settings_s eff_reg;
	logic [1:0] level_use;
	logic [15:0] level_words;
	lec_tx_e state_reg;
	lec_tx_e state_next;
	logic retry_sf_reg;
	logic last_loaded_reg;
	logic [CW-1:0] eop_cnt_reg;
	logic fifo_valid;
	logic fifo_ready;
	lec_pkg::lec_word_s fifo_data;
	logic [CW-1:0] fifo_count;
	logic push;
	logic pop;
	logic start;
	logic underrun;
	logic done;

	//////////////////////////////////////////////////////////////////////////
	// register access

	// byte-lane write mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			be_mask[i*lec_pkg::LEC_BYTE_BITS +: lec_pkg::LEC_BYTE_BITS] = {
				lec_pkg::LEC_BYTE_BITS{cfg_be_i[i]}};
		end
	end

	// next stored value; eeprom load wins over a software write
	always_comb begin
		settings_next = settings_reg;
		if (rom_load_i) begin
			settings_next = rom_data_i & lec_pkg::LEC_WRITABLE_MASK;
		end else if (cfg_sel_i && cfg_wr_i && cfg_addr_i == lec_pkg::LEC_SETTINGS_OFFSET) begin
			settings_next = (settings_reg & ~be_mask) | (cfg_wdata_i & be_mask);
			settings_next = settings_next & lec_pkg::LEC_WRITABLE_MASK;
		end
	end

	// stored settings
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			settings_reg <= lec_pkg::LEC_SETTINGS_RESET;
		end else begin
			settings_reg <= settings_next;
		end
	end

	// read port; unmapped offsets return zero
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_rdata_o <= '0;
			cfg_rvalid_o <= 1'b0;
		end else begin
			cfg_rvalid_o <= cfg_sel_i && cfg_rd_i;
			if (cfg_sel_i && cfg_rd_i && cfg_addr_i == lec_pkg::LEC_SETTINGS_OFFSET) begin
				cfg_rdata_o <= settings_reg;
			end else begin
				cfg_rdata_o <= '0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// applied settings

	// gate off returns every setting to its reset behaviour
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			eff_reg <= '{level: lec_pkg::LEC_LVL_1K7, default: 1'b0};
		end else if (host_enhancement_gate_i) begin
			eff_reg.level <= settings_reg[lec_pkg::LEC_LEVEL_LSB +: 2];
			eff_reg.prio <= settings_reg[lec_pkg::LEC_PRIO_BIT];
			eff_reg.idle <= settings_reg[lec_pkg::LEC_IDLE_BIT];
			eff_reg.accel <= settings_reg[lec_pkg::LEC_ACCEL_BIT];
		end else begin
			eff_reg <= '{level: lec_pkg::LEC_LVL_1K7, default: 1'b0};
		end
	end

	assign prio_req_en_o = eff_reg.prio;
	assign accel_adv_o = eff_reg.accel;

	//////////////////////////////////////////////////////////////////////////
	// transmit start control

	// after an underrun the retry runs store-and-forward
	assign level_use = retry_sf_reg ? lec_pkg::LEC_LVL_2K : eff_reg.level;

	// level in fifo words
	always_comb begin
		case (level_use)
			lec_pkg::LEC_LVL_2K: level_words = lec_pkg::LEC_BYTES_2K;
			lec_pkg::LEC_LVL_1K7: level_words = lec_pkg::LEC_BYTES_1K7;
			lec_pkg::LEC_LVL_1K: level_words = lec_pkg::LEC_BYTES_1K;
			default: level_words = lec_pkg::LEC_BYTES_512;
		endcase
		level_words = (level_words >> LVL_SHIFT) / 16'(lec_pkg::LEC_BYTES_PER_WORD);
	end

	assign push = at_in_valid_i && at_in_ready_o;
	assign pop = fifo_valid && fifo_ready;

	// whole packet present, or level reached when not store-and-forward
	assign start = (eop_cnt_reg != '0) ||
		(level_use != lec_pkg::LEC_LVL_2K && 16'(fifo_count) >= level_words);

	// fifo ran dry before the packet end left it
	assign underrun = state_reg == LEC_TX_SEND && !last_loaded_reg && !fifo_valid &&
		!tx_valid_o;
	assign done = state_reg == LEC_TX_SEND && last_loaded_reg && tx_valid_o && tx_ready_i;

	// pull in SEND while the output stage has room, pull every word in FLUSH, none in IDLE
	always_comb begin
		case (state_reg)
			LEC_TX_SEND: fifo_ready = !last_loaded_reg && (!tx_valid_o || tx_ready_i);
			LEC_TX_FLUSH: fifo_ready = 1'b1;
			default: fifo_ready = 1'b0;
		endcase
	end

	// packet sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LEC_TX_IDLE: begin
				if (start) begin
					state_next = LEC_TX_SEND;
				end
			end
			LEC_TX_SEND: begin
				if (underrun) begin
					state_next = LEC_TX_FLUSH;
				end else if (done) begin
					state_next = LEC_TX_IDLE;
				end
			end
			LEC_TX_FLUSH: begin
				if (pop && fifo_data.eop) begin
					state_next = LEC_TX_IDLE;
				end
			end
			default: begin
				state_next = LEC_TX_IDLE;
			end
		endcase
	end

	// state, retry mode and status outputs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= LEC_TX_IDLE;
			retry_sf_reg <= 1'b0;
			tx_underrun_o <= 1'b0;
			tx_active_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			tx_underrun_o <= underrun;
			tx_active_o <= state_next == LEC_TX_SEND;
			if (underrun) begin
				retry_sf_reg <= 1'b1;
			end else if (done) begin
				retry_sf_reg <= 1'b0;
			end
		end
	end

	// output word register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o <= '0;
			last_loaded_reg <= 1'b0;
		end else begin
			if (pop && state_reg == LEC_TX_SEND) begin
				tx_valid_o <= 1'b1;
				tx_data_o <= fifo_data;
				last_loaded_reg <= fifo_data.eop;
			end else if (tx_ready_i) begin
				tx_valid_o <= 1'b0;
			end
			if (state_reg != LEC_TX_SEND) begin
				last_loaded_reg <= 1'b0;
			end
		end
	end

	// complete packets held in the fifo
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			eop_cnt_reg <= '0;
		end else if (push && at_in_data_i.eop && !(pop && fifo_data.eop)) begin
			eop_cnt_reg <= CW'(eop_cnt_reg + 1'b1);
		end else if (pop && fifo_data.eop && !(push && at_in_data_i.eop)) begin
			eop_cnt_reg <= CW'(eop_cnt_reg - 1'b1);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// instances

	lec_fifo #(
		.WIDTH($bits(lec_pkg::lec_word_s)),
		.DEPTH(DEPTH),
		.CW(CW)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(at_in_valid_i),
		.in_ready_o(at_in_ready_o),
		.in_data_i(at_in_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_ready),
		.out_data_o(fifo_data),
		.count_o(fifo_count)
	);

	lec_turnaround u_turn (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.link_req_i(link_req_i),
		.link_release_i(link_release_i),
		.idle_en_i(eff_reg.idle),
		.ctl_value_i(link_ctl_value_i),
		.ctl_lines_i(phy_link_control_lines_i),
		.ctl_lines_o(phy_link_control_lines_o),
		.ctl_lines_oe_o(phy_link_control_lines_oe_o)
	);

	//////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	chk_reserved_bits_high_zero: assert property (settings_reg[31:14] == '0)
		else $error("bits 31-14 not zero");
	chk_reserved_bits_mid_zero: assert property (settings_reg[11:8] == '0)
		else $error("bits 11-8 not zero");
	chk_reserved_bits_low_zero: assert property (settings_reg[5:3] == '0)
		else $error("bits 5-3 not zero");
	chk_reserved_bits_bit_zero: assert property (!settings_reg[0] && !settings_reg[6])
		else $error("bit 0 or bit 6 not zero");
	chk_rom_load_value: assert property (rom_load_i |=>
		settings_reg == ($past(rom_data_i) & lec_pkg::LEC_WRITABLE_MASK))
		else $error("eeprom load not stored");
	chk_gate_off_quiet: assert property (!host_enhancement_gate_i |=>
		!prio_req_en_o && !accel_adv_o && eff_reg.level == lec_pkg::LEC_LVL_1K7)
		else $error("settings active with gate clear");
	chk_prio_follows: assert property (host_enhancement_gate_i &&
		settings_reg[lec_pkg::LEC_PRIO_BIT] |=> prio_req_en_o)
		else $error("priority enable not applied");
	chk_sf_no_start: assert property (state_reg == LEC_TX_IDLE &&
		level_use == lec_pkg::LEC_LVL_2K && eop_cnt_reg == '0 |=> state_reg != LEC_TX_SEND)
		else $error("store-and-forward started without packet end");
	chk_level_start: assert property (state_reg == LEC_TX_IDLE &&
		16'(fifo_count) >= level_words && level_use != lec_pkg::LEC_LVL_2K |=> tx_active_o)
		else $error("level reached but no start");
	chk_underrun_retry: assert property (underrun |=> tx_underrun_o && retry_sf_reg &&
		level_use == lec_pkg::LEC_LVL_2K)
		else $error("underrun not followed by store-and-forward");

endmodule

// *** verification/lec_phy_model.sv ***
// lec_phy_model: phy side of the link, grants the control lines and paces the transmitter
// assumes the link request is seen as a level and the link drives only while its enable is high
`timescale 1ns/10ps
module lec_phy_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// link side of the control lines
	input wire logic req_i,
	input wire logic slow_i,
	input wire logic link_oe_i,
	input wire logic [1:0] link_lines_i,
	output logic [1:0] lines_o,
	// transmitter pacing
	input wire logic stall_i,
	output logic tx_ready_o
);
	logic own_reg;
	logic was_oe_reg;
	logic [1:0] val_reg;
	logic [1:0] last_reg;
	logic [2:0] wait_reg;

	////////////////////////////////////////////////////////////////////////////////
	// wire level: released lines show the inverse of the last level
	assign lines_o = link_oe_i ? link_lines_i : (own_reg ? val_reg : ~last_reg);
	assign tx_ready_o = !stall_i;

	// ownership, grant after a prompt or slow wait, take back after the link lets go
	always_ff @(posedge clk_i) begin
		last_reg <= lines_o;
		was_oe_reg <= link_oe_i;
		if (sys_rst_i) begin
			own_reg <= 1'b1;
			val_reg <= lec_pkg::LEC_CTL_IDLE;
			wait_reg <= 3'h0;
		end else if (was_oe_reg && !link_oe_i) begin
			own_reg <= 1'b1;
			val_reg <= lec_pkg::LEC_CTL_IDLE;
			wait_reg <= 3'h0;
		end else if (own_reg && val_reg == lec_pkg::LEC_CTL_GRANT) begin
			own_reg <= 1'b0;
		end else if (own_reg && req_i && wait_reg == (slow_i ? 3'h5 : 3'h0)) begin
			val_reg <= lec_pkg::LEC_CTL_GRANT;
		end else if (own_reg && req_i) begin
			wait_reg <= wait_reg + 3'h1;
		end
	end
endmodule

// *** verification/link_enhancement_control_bench.sv ***
// link_enhancement_control_bench: self-checking bench for the enhancement settings block
// assumes lec_core with a 16-word fifo and start levels shifted down to words
`timescale 1ns/10ps
module link_enhancement_control_bench;
	localparam logic [7:0] OFF = lec_pkg::LEC_SETTINGS_OFFSET;
	localparam logic [31:0] MASK = lec_pkg::LEC_WRITABLE_MASK;
	logic clk_i, sys_rst_i, cfg_sel_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o, rom_load_i;
	logic host_enhancement_gate_i, at_in_valid_i, at_in_ready_o, tx_valid_o, tx_ready_i;
	logic tx_active_o, tx_underrun_o, link_req_i, link_release_i, prio_req_en_o, accel_adv_o;
	logic phy_link_control_lines_oe_o, slow, stall, act_prev;
	logic [7:0] cfg_addr_i;
	logic [3:0] cfg_be_i;
	logic [31:0] cfg_wdata_i, cfg_rdata_o, rom_data_i, d;
	logic [1:0] link_ctl_value_i, phy_link_control_lines_i, phy_link_control_lines_o;
	lec_pkg::lec_word_s at_in_data_i, tx_data_o;
	int errors, n_tests, cycles, underruns, n_pushed, start_at, u0, w;
	integer seed = 32'h7c30_4595;
	logic [31:0] rd_q[$];
	lec_pkg::lec_word_s tx_q[$];

	////////////////////////////////////////////////////////////////////////////////
	lec_core #(.DEPTH(16), .LVL_SHIFT(6)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.cfg_sel_i(cfg_sel_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
		.cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
		.cfg_rvalid_o(cfg_rvalid_o), .rom_load_i(rom_load_i), .rom_data_i(rom_data_i),
		.host_enhancement_gate_i(host_enhancement_gate_i), .at_in_valid_i(at_in_valid_i),
		.at_in_ready_o(at_in_ready_o), .at_in_data_i(at_in_data_i), .tx_valid_o(tx_valid_o),
		.tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .tx_active_o(tx_active_o),
		.tx_underrun_o(tx_underrun_o), .link_req_i(link_req_i), .link_release_i(link_release_i),
		.link_ctl_value_i(link_ctl_value_i), .phy_link_control_lines_i(phy_link_control_lines_i),
		.phy_link_control_lines_o(phy_link_control_lines_o),
		.phy_link_control_lines_oe_o(phy_link_control_lines_oe_o),
		.prio_req_en_o(prio_req_en_o), .accel_adv_o(accel_adv_o));
	lec_phy_model phy (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(link_req_i), .slow_i(slow),
		.link_oe_i(phy_link_control_lines_oe_o), .link_lines_i(phy_link_control_lines_o),
		.lines_o(phy_link_control_lines_i), .stall_i(stall), .tx_ready_o(tx_ready_i));

	////////////////////////////////////////////////////////////////////////////////
	// clock
	always #4 clk_i = ~clk_i;

	// compare and report
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchers: read data, transmitted words, underruns, start point, stalls, timeout
	always @(posedge clk_i) begin
		if (cfg_rvalid_o === 1'b1) begin
			if (rd_q.size() == 0) rd_q.push_back(~cfg_rdata_o);
			check({1'b0, cfg_rdata_o}, {1'b0, rd_q.pop_front()});
		end
		if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
			if (tx_q.size() == 0) tx_q.push_back(~tx_data_o);
			check(tx_data_o, tx_q.pop_front());
		end
		if (tx_underrun_o === 1'b1) underruns++;
		if (tx_active_o === 1'b1 && act_prev !== 1'b1) start_at = n_pushed;
		act_prev <= tx_active_o;
		stall <= (($random(seed) & 3) == 0);
		cycles++;
		if (cycles == 30000) begin
			errors++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register port, held for one taken edge, then released for one edge
	task automatic reg_op(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] v);
		cfg_sel_i <= 1'b1;
		cfg_wr_i <= wr;
		cfg_rd_i <= !wr;
		cfg_addr_i <= a;
		cfg_be_i <= be;
		cfg_wdata_i <= v;
		@(posedge clk_i);
		cfg_sel_i <= 1'b0;
		cfg_wr_i <= 1'b0;
		cfg_rd_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		reg_op(1'b0, a, 4'h0, 32'h0000_0000);
	endtask

	// eeprom load strobe, with or without a software write in the same cycle
	task automatic rom_op(input logic [31:0] v, input logic sw);
		rom_load_i <= 1'b1;
		rom_data_i <= v;
		cfg_sel_i <= sw;
		cfg_wr_i <= sw;
		cfg_addr_i <= OFF;
		cfg_be_i <= 4'hf;
		cfg_wdata_i <= 32'h0000_0000;
		@(posedge clk_i);
		{rom_load_i, cfg_sel_i, cfg_wr_i} <= 3'h0;
		@(posedge clk_i);
	endtask

	// fill side: one word held until taken
	task automatic push(input logic eop, input logic keep);
		lec_pkg::lec_word_s wd;
		wd.eop = eop;
		wd.data = $random(seed);
		if (keep) tx_q.push_back(wd);
		at_in_valid_i <= 1'b1;
		at_in_data_i <= wd;
		do @(posedge clk_i); while (at_in_ready_o !== 1'b1);
		n_pushed++;
	endtask

	// packet of n words, pausing after hold words to see that nothing starts
	task automatic push_pkt(input int n, input int hold, input logic keep);
		for (int i = 0; i < n; i++) begin
			if (i == hold) begin
				at_in_valid_i <= 1'b0;
				repeat (8) @(posedge clk_i);
				check({32'h0, tx_active_o}, 33'h0);
			end
			push(i == n - 1, keep);
		end
		at_in_valid_i <= 1'b0;
		@(posedge clk_i);
		if (n == 16) check({32'h0, at_in_ready_o}, 33'h0);
	endtask

	task automatic drain();
		for (int i = 0; i < 400 && tx_q.size() > 0; i++) @(posedge clk_i);
		check(tx_q.size(), 0);
	endtask

	// request the lines and count edges from grant to drive
	task automatic turn(input int exp_n);
		int n;
		link_req_i <= 1'b1;
		for (n = 0; n < 50 && phy_link_control_lines_i !== 2'h3; n++) @(posedge clk_i);
		link_req_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (phy_link_control_lines_oe_o !== 1'b1 && n < 10);
		check(n, exp_n);
		check(phy_link_control_lines_i, link_ctl_value_i);
		link_release_i <= 1'b1;
		@(posedge clk_i);
		link_release_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check(phy_link_control_lines_oe_o, 0);
		$display("test turnaround done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{clk_i, cfg_sel_i, cfg_wr_i, cfg_rd_i, rom_load_i, at_in_valid_i, link_req_i} = '0;
		{link_release_i, slow, stall, act_prev, cfg_addr_i, cfg_be_i} = '0;
		{cfg_wdata_i, rom_data_i, at_in_data_i} = '0;
		{errors, n_tests, cycles, underruns, n_pushed, start_at} = '0;
		link_ctl_value_i = 2'h1;
		host_enhancement_gate_i = 1'b1;
		sys_rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reg_rd(OFF, lec_pkg::LEC_SETTINGS_RESET);
		reg_op(1'b1, OFF, 4'hf, 32'hffff_ffff);
		reg_rd(OFF, 32'h0000_3086);
		reg_op(1'b1, OFF, 4'h1, 32'h0000_0000);
		reg_rd(OFF, 32'h0000_3000);
		d = $random(seed);
		reg_op(1'b1, OFF, 4'hf, d);
		reg_rd(OFF, d & MASK);
		reg_rd(8'hf8, 32'h0000_0000);
		rom_op(32'hffff_ffff, 1'b1);
		reg_rd(OFF, 32'h0000_3086);
		d = $random(seed);
		rom_op(d, 1'b0);
		reg_rd(OFF, d & MASK);
		$display("test register access done");
		reg_op(1'b1, OFF, 4'hf, 32'h0000_0086);
		repeat (3) @(posedge clk_i);
		check({prio_req_en_o, accel_adv_o}, 2'h3);
		turn(2);
		host_enhancement_gate_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check({prio_req_en_o, accel_adv_o}, 2'h0);
		turn(1);
		host_enhancement_gate_i <= 1'b1;
		slow <= 1'b1;
		reg_op(1'b1, OFF, 4'hf, 32'h0000_0082);
		repeat (3) @(posedge clk_i);
		turn(1);
		slow <= 1'b0;
		reg_op(1'b1, OFF, 4'hf, 32'h0000_3086);
		push_pkt(2, 2, 1'b1);
		drain();
		// two words reach the level, the packet end arrives only after the fifo ran dry
		u0 = underruns;
		push(1'b0, 1'b1);
		push(1'b0, 1'b1);
		at_in_valid_i <= 1'b0;
		for (int i = 0; i < 60 && underruns == u0; i++) @(posedge clk_i);
		check(underruns - u0, 1);
		push(1'b1, 1'b0);
		at_in_valid_i <= 1'b0;
		@(posedge clk_i);
		push_pkt(16, 15, 1'b1);
		drain();
		$display("test underrun retry done");
		reg_op(1'b1, OFF, 4'hf, 32'h0000_0086);
		push_pkt(5, 4, 1'b1);
		drain();
		for (int k = 1; k < 4; k++) begin
			reg_op(1'b1, OFF, 4'hf, 32'h0000_0086 | (k << 12));
			w = 8 - 2 * k;
			n_pushed = 0;
			push_pkt(12, w - 1, 1'b1);
			drain();
			check({32'h0, start_at >= w && start_at <= w + 2}, 33'h1);
		end
		$display("test start levels done");
		complete_run();
	end
endmodule
